// [hw/npe_params.svh]
`ifndef NPE_PARAMS_SVH
`define NPE_PARAMS_SVH

// Register byte offsets.
`define NPE_OFF_CTRL 8'h00
`define NPE_OFF_MODE 8'h04
`define NPE_OFF_STAT 8'h08
`define NPE_OFF_PAR  8'h0C
`define NPE_OFF_NPAR 8'h10

// Field positions.
`define NPE_CLR_BIT 0
`define NPE_REC_BIT 0
`define NPE_ECC_BIT 1
`define NPE_MUL_BIT 2

// Page lengths in words for each page length code.
`define NPE_LEN_0 13'h0210
`define NPE_LEN_1 13'h0420
`define NPE_LEN_2 13'h0840
`define NPE_LEN_3 13'h1080

// Active word index levels for each page length code.
`define NPE_LMSK_0 12'h03FF
`define NPE_LMSK_1 12'h07FF
`define NPE_LMSK_2 12'h0FFF
`define NPE_LMSK_3 12'h0FFF

// Active bit index levels for byte and halfword words.
`define NPE_CMSK_8  4'h7
`define NPE_CMSK_16 4'hF

// Bus responses.
`define NPE_RESP_OK  2'h0
`define NPE_RESP_ERR 2'h2

`endif

// [hw/npe_pkg.sv]
package npe_pkg;

    // Write channel states, one-hot.
    typedef enum logic [1:0] {
        npe_w_idle = 2'b01,
        npe_w_resp = 2'b10
    } npe_wst_t;

    // Whole state of the block.
    typedef struct packed {
        npe_wst_t    wst;
        logic        aw_held;
        logic [7:0]  aw_addr;
        logic        w_held;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic [1:0]  bresp;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
        logic [1:0]  page_length_code;
        logic [12:0] word_cnt;
        logic [3:0]  col_par;
        logic [3:0]  col_npar;
        logic [11:0] line_par;
        logic [11:0] line_npar;
        logic        recoverable_err_flag;
        logic        check_bytes_err_flag;
        logic        multi_err_flag;
    } npe_state_t;

    localparam npe_state_t NPE_RST = '{wst: npe_w_idle, default: '0};

endpackage : npe_pkg

// [hw/npe_top.sv]
// Implementation choice: the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "npe_params.svh"

module npe_top (
    input  wire logic        ref_clk_in,
    input  wire logic        rst_n_in,
    input  wire logic        s_axi_awvalid_in,
    output logic             s_axi_awready_out,
    input  wire logic [7:0]  s_axi_awaddr_in,
    input  wire logic        s_axi_wvalid_in,
    output logic             s_axi_wready_out,
    input  wire logic [31:0] s_axi_wdata_in,
    input  wire logic [3:0]  s_axi_wstrb_in,
    output logic             s_axi_bvalid_out,
    input  wire logic        s_axi_bready_in,
    output logic [1:0]       s_axi_bresp_out,
    input  wire logic        s_axi_arvalid_in,
    output logic             s_axi_arready_out,
    input  wire logic [7:0]  s_axi_araddr_in,
    output logic             s_axi_rvalid_out,
    input  wire logic        s_axi_rready_in,
    output logic [31:0]      s_axi_rdata_out,
    output logic [1:0]       s_axi_rresp_out,
    input  wire logic        bus16_in,
    input  wire logic        data_valid_in,
    input  wire logic [15:0] data_in,
    input  wire logic        check_valid_in,
    input  wire logic [15:0] stored_par_in,
    input  wire logic [15:0] stored_npar_in
);

    npe_pkg::npe_state_t s;
    npe_pkg::npe_state_t n;

    logic        wr_go;
    logic        clr_fire;
    logic [15:0] dm;
    logic        wp;
    logic [15:0] pmask;
    logic [15:0] bpar;
    logic [15:0] bnpar;
    logic [15:0] sp;
    logic [15:0] sn;
    logic        chk_any;
    logic        chk_onehot;
    logic        chk_single;

    // Page length in words for a length code.
    function automatic logic [12:0] page_words(input logic [1:0] c);
        case (c)
            2'h0: page_words = `NPE_LEN_0;
            2'h1: page_words = `NPE_LEN_1;
            2'h2: page_words = `NPE_LEN_2;
            default: page_words = `NPE_LEN_3;
        endcase
    endfunction : page_words

    // Word index levels in use; the index field is twelve bits wide,
    // so the longest page folds its top index bit away.
    function automatic logic [11:0] line_mask(input logic [1:0] c);
        case (c)
            2'h0: line_mask = `NPE_LMSK_0;
            2'h1: line_mask = `NPE_LMSK_1;
            2'h2: line_mask = `NPE_LMSK_2;
            default: line_mask = `NPE_LMSK_3;
        endcase
    endfunction : line_mask

    // Data bits whose bit index has bit k set.
    function automatic logic [15:0] col_sel(input logic [1:0] k);
        case (k)
            2'h0: col_sel = 16'hAAAA;
            2'h1: col_sel = 16'hCCCC;
            2'h2: col_sel = 16'hF0F0;
            default: col_sel = 16'hFF00;
        endcase
    endfunction : col_sel

    // Both address and data held and no response pending.
    assign wr_go = s.aw_held && s.w_held && (s.wst == npe_pkg::npe_w_idle);
    assign clr_fire = wr_go && (s.aw_addr == `NPE_OFF_CTRL) && s.wstrb[0]
                      && s.wdata[`NPE_CLR_BIT];

    // Byte mode ignores the upper data lane.
    assign dm = bus16_in ? data_in : {8'h00, data_in[7:0]};
    assign wp = ^dm;
    assign pmask = {line_mask(s.page_length_code),
                    bus16_in ? `NPE_CMSK_16 : `NPE_CMSK_8};

    // Parity as it stands this cycle, after any clear.
    assign bpar  = clr_fire ? 16'h0000 : {s.line_par, s.col_par};
    assign bnpar = clr_fire ? 16'h0000 : {s.line_npar, s.col_npar};

    // Syndrome from computed against stored parity.
    assign sp = (bpar ^ stored_par_in) & pmask;
    assign sn = (bnpar ^ stored_npar_in) & pmask;
    assign chk_any = |(sp | sn);
    // A lone flipped stored bit leaves exactly one syndrome bit set.
    assign chk_onehot = $onehot({sp, sn});
    // A data bit error flips exactly one side of every level.
    assign chk_single = ((sp ^ sn) == pmask);

    // Handshake outputs from state; data outputs from flip-flops.
    assign s_axi_awready_out = !s.aw_held && (s.wst == npe_pkg::npe_w_idle);
    assign s_axi_wready_out  = !s.w_held && (s.wst == npe_pkg::npe_w_idle);
    assign s_axi_bvalid_out  = (s.wst == npe_pkg::npe_w_resp);
    assign s_axi_bresp_out   = s.bresp;
    assign s_axi_arready_out = !s.rvalid;
    assign s_axi_rvalid_out  = s.rvalid;
    assign s_axi_rdata_out   = s.rdata;
    assign s_axi_rresp_out   = s.rresp;

    // Next state: bus slave, parity accumulation and page check.
    always_comb begin : p_next
        logic        last;
        logic [15:0] sel;
        last = 1'b0;
        sel = 16'h0000;
        n = s;

        // Address and data are taken in either order.
        if (s_axi_awvalid_in && s_axi_awready_out) begin
            n.aw_held = 1'b1;
            n.aw_addr = s_axi_awaddr_in;
        end
        if (s_axi_wvalid_in && s_axi_wready_out) begin
            n.w_held = 1'b1;
            n.wdata = s_axi_wdata_in;
            n.wstrb = s_axi_wstrb_in;
        end

        // Write execution; read-only registers accept and ignore writes.
        case (s.wst)
            npe_pkg::npe_w_idle: begin
                if (wr_go) begin
                    n.aw_held = 1'b0;
                    n.w_held = 1'b0;
                    n.wst = npe_pkg::npe_w_resp;
                    n.bresp = `NPE_RESP_OK;
                    if (s.aw_addr == `NPE_OFF_MODE) begin
                        if (s.wstrb[0]) begin
                            n.page_length_code = s.wdata[1:0];
                        end
                    end else if (s.aw_addr == `NPE_OFF_CTRL) begin
                        n.bresp = `NPE_RESP_OK;
                    end else if (s.aw_addr == `NPE_OFF_STAT ||
                                 s.aw_addr == `NPE_OFF_PAR ||
                                 s.aw_addr == `NPE_OFF_NPAR) begin
                        n.bresp = `NPE_RESP_OK;
                    end else begin
                        n.bresp = `NPE_RESP_ERR;
                    end
                end
            end
            npe_pkg::npe_w_resp: begin
                if (s_axi_bready_in) begin
                    n.wst = npe_pkg::npe_w_idle;
                end
            end
            default: n.wst = npe_pkg::npe_w_idle;
        endcase

        // Read decode; the write-only control register reads as zero.
        if (s.rvalid && s_axi_rready_in) begin
            n.rvalid = 1'b0;
        end
        if (s_axi_arvalid_in && s_axi_arready_out) begin
            n.rvalid = 1'b1;
            n.rresp = `NPE_RESP_OK;
            n.rdata = 32'h0000_0000;
            if (s_axi_araddr_in == `NPE_OFF_CTRL) begin
                n.rdata = 32'h0000_0000;
            end else if (s_axi_araddr_in == `NPE_OFF_MODE) begin
                n.rdata = {30'h0000_0000, s.page_length_code};
            end else if (s_axi_araddr_in == `NPE_OFF_STAT) begin
                n.rdata[`NPE_REC_BIT] = s.recoverable_err_flag;
                n.rdata[`NPE_ECC_BIT] = s.check_bytes_err_flag;
                n.rdata[`NPE_MUL_BIT] = s.multi_err_flag;
            end else if (s_axi_araddr_in == `NPE_OFF_PAR) begin
                n.rdata = {16'h0000, s.line_par, s.col_par};
            end else if (s_axi_araddr_in == `NPE_OFF_NPAR) begin
                n.rdata = {16'h0000, s.line_npar, s.col_npar};
            end else begin
                n.rresp = `NPE_RESP_ERR;
            end
        end

        // Clear zeroes parity and restarts the page.
        {n.line_par, n.col_par} = bpar;
        {n.line_npar, n.col_npar} = bnpar;
        if (clr_fire) begin
            n.word_cnt = 13'h0000;
            n.recoverable_err_flag = 1'b0;
            n.check_bytes_err_flag = 1'b0;
            n.multi_err_flag = 1'b0;
        end

        if (check_valid_in) begin
            // Syndrome locates the fault; check wins.
            {n.line_par, n.col_par} = sp;
            {n.line_npar, n.col_npar} = sn;
            n.word_cnt = 13'h0000;
            n.recoverable_err_flag = chk_any;
            n.check_bytes_err_flag = chk_onehot;
            // Neither clean, single nor check byte error.
            n.multi_err_flag = chk_any && !chk_single && !chk_onehot;
        end else if (data_valid_in) begin
            // Bit index levels split the word's bits.
            for (int k = 0; k < 4; k++) begin
                sel = col_sel(2'(k));
                if (pmask[k]) begin
                    n.col_par[k] = bpar[k] ^ (^(dm & sel));
                    n.col_npar[k] = bnpar[k] ^ (^(dm & ~sel));
                end
            end
            // Word index levels split the words.
            for (int i = 0; i < 12; i++) begin
                if (pmask[i+4]) begin
                    if (n.word_cnt[i]) begin
                        n.line_par[i] = bpar[i+4] ^ wp;
                    end else begin
                        n.line_npar[i] = bnpar[i+4] ^ wp;
                    end
                end
            end
            // Word counter wraps at the page length.
            last = (n.word_cnt == 13'(page_words(s.page_length_code) - 13'h0001));
            n.word_cnt = last ? 13'h0000 : 13'(n.word_cnt + 13'h0001);
        end
    end

    // State register; reset loads a constant only.
    always_ff @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
            s <= npe_pkg::NPE_RST;
        end else begin
            s <= n;
        end
    end

    default clocking cb @(posedge ref_clk_in);
    endclocking
    default disable iff (!rst_n_in);

    sequence s_check;
        check_valid_in;
    endsequence

    sequence s_quiet;
        !data_valid_in && !check_valid_in;
    endsequence

    sequence s_acc;
        data_valid_in && !check_valid_in && !clr_fire;
    endsequence

    sequence s_ctrl_zero;
        wr_go && (s.aw_addr == `NPE_OFF_CTRL) && !s.wdata[`NPE_CLR_BIT];
    endsequence

    property p_clear;
        clr_fire ##0 s_quiet |=> ({s.line_par, s.col_par} == 16'h0000)
                                 && ({s.line_npar, s.col_npar} == 16'h0000);
    endproperty
    a_clear: assert property (p_clear) else $error("Clear left parity set.");

    property p_clear_none;
        s_ctrl_zero ##0 s_quiet |=> $stable(s.line_par) && $stable(s.col_npar);
    endproperty
    a_clear_none: assert property (p_clear_none) else $error("Zero clear changed parity.");

    property p_wrap;
        s_acc ##0 (s.word_cnt == 13'(page_words(s.page_length_code) - 13'h0001))
            |=> (s.word_cnt == 13'h0000);
    endproperty
    a_wrap: assert property (p_wrap) else $error("Word counter missed page end.");

    property p_line;
        s_acc ##0 s.word_cnt[0] |=> s.line_par[0] == ($past(s.line_par[0]) ^ $past(wp))
                                    && $stable(s.line_npar[0]);
    endproperty
    a_line: assert property (p_line) else $error("Odd word parity misplaced.");

    property p_byte;
        s_acc ##0 !bus16_in |=> $stable(s.col_par[3]) && $stable(s.col_npar[3]);
    endproperty
    a_byte: assert property (p_byte) else $error("Byte word used upper lane.");

    property p_rec;
        s_check |=> (s.recoverable_err_flag == $past(chk_any));
    endproperty
    a_rec: assert property (p_rec) else $error("Recoverable flag wrong.");

    property p_multi;
        s.multi_err_flag |-> s.recoverable_err_flag && !s.check_bytes_err_flag;
    endproperty
    a_multi: assert property (p_multi) else $error("Multiple flag inconsistent.");

    property p_eccb;
        s_check ##0 chk_onehot |=> s.check_bytes_err_flag && !s.multi_err_flag;
    endproperty
    a_eccb: assert property (p_eccb) else $error("Check byte error missed.");

    property p_eccpos;
        $rose(s.check_bytes_err_flag) |->
            $onehot({s.line_par, s.col_par, s.line_npar, s.col_npar});
    endproperty
    a_eccpos: assert property (p_eccpos) else $error("Check bit position lost.");

    property p_loc;
        s_check ##0 chk_single |=> ({s.line_par, s.col_par} == $past(sp))
                                   && !s.multi_err_flag;
    endproperty
    a_loc: assert property (p_loc) else $error("Error location wrong.");

    property p_bresp;
        s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in && s_axi_wready_out
            |-> ##[1:2] s_axi_bvalid_out;
    endproperty
    a_bresp: assert property (p_bresp) else $error("Write response late.");

endmodule : npe_top

// [tb/npe_flash_model.sv]
`timescale 1ns/1ps

// Behavioural flash: programs a page of counted words, reads it back with commanded flips,
// then presents the spare-area check bytes for one cycle.
module npe_flash_model (
    input  wire logic        clk_in,
    input  wire logic        start_in,
    input  wire logic        prog_in,
    input  wire logic [12:0] len_in,
    input  wire logic [3:0]  gap_in,
    input  wire logic [12:0] flip_word_in,
    input  wire logic [15:0] flip_mask_in,
    input  wire logic [15:0] flip_spare_in,
    input  wire logic [15:0] spare_par_in,
    input  wire logic [15:0] spare_npar_in,
    input  wire logic        spare_we_in,
    output logic             busy_out,
    output logic             valid_out,
    output logic [15:0]      data_out,
    output logic             check_out,
    output logic [15:0]      par_out,
    output logic [15:0]      npar_out
);
    logic [15:0] mem [0:4223];
    logic [15:0] spare_p;
    logic [15:0] spare_n;
    logic [12:0] idx;
    logic [3:0]  wait_cnt;
    logic        rd;

    initial begin
        busy_out = 1'h0;
        valid_out = 1'h0;
        check_out = 1'h0;
        data_out = 16'h0;
        par_out = 16'h0;
        npar_out = 16'h0;
    end

    // Idle lines flip every cycle so a stale value can never pass for a real word.
    always @(posedge clk_in) begin
        valid_out <= 1'h0;
        check_out <= 1'h0;
        data_out <= ~data_out;
        par_out <= ~par_out;
        npar_out <= ~npar_out;
        if (spare_we_in) begin
            spare_p <= spare_par_in;
            spare_n <= spare_npar_in;
        end
        if (start_in) begin
            busy_out <= 1'h1;
            idx <= 13'h0;
            wait_cnt <= 4'h0;
            rd <= !prog_in;
        end else if (busy_out) begin
            if (idx == len_in) begin
                busy_out <= 1'h0;
                check_out <= rd;
                par_out <= spare_p ^ flip_spare_in;
                npar_out <= spare_n;
            end else if (wait_cnt != gap_in) begin
                wait_cnt <= wait_cnt + 4'h1;
            end else begin
                wait_cnt <= 4'h0;
                idx <= idx + 13'h1;
                valid_out <= 1'h1;
                if (rd) begin
                    data_out <= mem[idx] ^ ((idx == flip_word_in) ? flip_mask_in : 16'h0);
                end else begin
                    data_out <= {idx[4:0], idx[12:2]} ^ 16'hC3A5;
                    mem[idx] <= {idx[4:0], idx[12:2]} ^ 16'hC3A5;
                end
            end
        end
    end
endmodule : npe_flash_model

// [tb/testbench.sv]
`timescale 1ns/1ps
`include "npe_params.svh"

module testbench;
    logic        ref_clk_in = 1'h0;
    logic        rst_n_in = 1'h0;
    logic        awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [1:0]  bresp, rresp;
    logic [7:0]  awaddr = 8'h0, araddr = 8'h0;
    logic [31:0] wdata = 32'h0, rdata;
    logic        bus16 = 1'h0, st = 1'h0, prog = 1'h0, swe = 1'h0;
    logic        fl_valid, fl_check, fl_busy;
    logic [15:0] fl_data, fl_par, fl_npar;
    logic [15:0] fmask = 16'h0, fspare = 16'h0, sp = 16'h0, sn = 16'h0, ep, en;
    logic [12:0] len = 13'h0210, fword = 13'h0, widx;
    logic [3:0]  gap = 4'h0, cm;
    logic [11:0] lm;
    int          fail_count = 0;
    int          compares = 0;

    always #2 ref_clk_in = ~ref_clk_in;

    npe_top dut (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .s_axi_awvalid_in(awvalid),
        .s_axi_awready_out(awready), .s_axi_awaddr_in(awaddr), .s_axi_wvalid_in(wvalid),
        .s_axi_wready_out(wready), .s_axi_wdata_in(wdata), .s_axi_wstrb_in(4'hF),
        .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready), .s_axi_bresp_out(bresp),
        .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready), .s_axi_araddr_in(araddr),
        .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready), .s_axi_rdata_out(rdata),
        .s_axi_rresp_out(rresp), .bus16_in(bus16), .data_valid_in(fl_valid),
        .data_in(fl_data), .check_valid_in(fl_check), .stored_par_in(fl_par),
        .stored_npar_in(fl_npar));

    npe_flash_model flash (.clk_in(ref_clk_in), .start_in(st), .prog_in(prog), .len_in(len),
        .gap_in(gap), .flip_word_in(fword), .flip_mask_in(fmask), .flip_spare_in(fspare),
        .spare_par_in(sp), .spare_npar_in(sn), .spare_we_in(swe), .busy_out(fl_busy),
        .valid_out(fl_valid), .data_out(fl_data), .check_out(fl_check), .par_out(fl_par),
        .npar_out(fl_npar));

    // Accumulates the parity every word on the data path should leave behind.
    always @(posedge ref_clk_in) begin
        if (fl_valid) begin
            for (int j = 0; j < 16; j++) begin
                if (fl_data[j] && 4'(j) <= cm) begin
                    ep = ep ^ {widx[11:0] & lm, 4'(j) & cm};
                    en = en ^ {~widx[11:0] & lm, ~4'(j) & cm};
                end
            end
            widx = (widx == len - 13'h1) ? 13'h0 : widx + 13'h1;
        end
    end

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic end_of_test;
        $display("Comparisons %0d, mismatches %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : end_of_test

    // Address and data go out together; each is dropped at the edge that takes it.
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        int n;
        n = 0;
        @(posedge ref_clk_in);
        awvalid <= 1'h1;
        awaddr <= a;
        wvalid <= 1'h1;
        wdata <= d;
        bready <= 1'h1;
        do begin
            @(posedge ref_clk_in);
            n++;
            if (awvalid && awready) awvalid <= 1'h0;
            if (wvalid && wready) wvalid <= 1'h0;
        end while (!bvalid && n < 64);
        bready <= 1'h0;
        if (!bvalid) fail_count++;
        chk("write response", 32'(bresp), 32'(er));
    endtask : axi_wr

    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, input logic [1:0] er);
        int n;
        n = 0;
        @(posedge ref_clk_in);
        arvalid <= 1'h1;
        araddr <= a;
        rready <= 1'h1;
        do begin
            @(posedge ref_clk_in);
            n++;
            if (arvalid && arready) arvalid <= 1'h0;
        end while (!rvalid && n < 64);
        rready <= 1'h0;
        if (!rvalid) fail_count++;
        d = rdata;
        chk("read response", 32'(rresp), 32'(er));
    endtask : axi_rd

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input string what,
                          output logic [31:0] d);
        axi_rd(a, d, `NPE_RESP_OK);
        chk(what, d, e);
    endtask : rd_chk

    // Clearing also restarts the bench's own page tally.
    task automatic clr;
        axi_wr(`NPE_OFF_CTRL, 32'h1, `NPE_RESP_OK);
        ep = 16'h0;
        en = 16'h0;
        widx = 13'h0;
    endtask : clr

    task automatic run_flash(input logic p, input logic [12:0] fw, input logic [15:0] fmk,
                             input logic [15:0] fs);
        int n;
        n = 0;
        @(posedge ref_clk_in);
        st <= 1'h1;
        prog <= p;
        fword <= fw;
        fmask <= fmk;
        fspare <= fs;
        @(posedge ref_clk_in);
        st <= 1'h0;
        do begin
            @(posedge ref_clk_in);
            n++;
        end while (fl_busy && n < 40000);
        if (fl_busy) fail_count++;
    endtask : run_flash

    task automatic reg_test;
        logic [31:0] d;
        for (int a = 0; a < 5; a++) rd_chk(8'(a * 4), 32'h0, "reset value", d);
        axi_rd(8'h14, d, `NPE_RESP_ERR);
        chk("unmapped read", d, 32'h0);
        axi_wr(8'h14, 32'hFFFF_FFFF, `NPE_RESP_ERR);
        axi_wr(`NPE_OFF_STAT, 32'h7, `NPE_RESP_OK);
        rd_chk(`NPE_OFF_STAT, 32'h0, "read-only status", d);
    endtask : reg_test

    task automatic prog_pass(input logic [1:0] c);
        logic [31:0] d;
        bus16 <= c[0];
        len <= 13'h0210 << c;
        gap <= (c == 2'h1) ? 4'h2 : 4'h0;
        lm = (c == 2'h0) ? 12'h3FF : (c == 2'h1) ? 12'h7FF : 12'hFFF;
        cm = c[0] ? 4'hF : 4'h7;
        axi_wr(`NPE_OFF_MODE, 32'(c), `NPE_RESP_OK);
        rd_chk(`NPE_OFF_MODE, 32'(c), "page length code", d);
        clr();
        run_flash(1'h1, 13'h0, 16'h0, 16'h0);
        rd_chk(`NPE_OFF_PAR, {16'h0, ep}, "page parity", d);
        rd_chk(`NPE_OFF_NPAR, {16'h0, en}, "page inverse parity", d);
        axi_wr(`NPE_OFF_CTRL, 32'h0, `NPE_RESP_OK);
        rd_chk(`NPE_OFF_PAR, {16'h0, ep}, "parity after zero write", d);
        sp <= d[15:0];
        sn <= en;
        swe <= 1'h1;
        clr();
        swe <= 1'h0;
        rd_chk(`NPE_OFF_NPAR, 32'h0, "inverse parity after clear", d);
    endtask : prog_pass

    // Clean, single, double and check-byte faults on read-back of the page.
    task automatic read_pass(input logic [1:0] c);
        logic [15:0] fmk [4];
        logic [2:0]  esr [4];
        logic [15:0] one;
        logic [31:0] d, d2;
        fmk = '{16'h0, 16'h0, 16'h0003, 16'h0};
        fmk[1][{c[0], 3'h7}] = 1'h1;
        esr = '{3'h0, 3'h1, 3'h5, 3'h3};
        one = {(len[11:0] - 12'h1) & lm, {c[0], 3'h7} & cm};
        for (int k = 0; k < 4; k++) begin
            clr();
            run_flash(1'h0, (k == 1) ? len - 13'h1 : 13'h5, fmk[k], (k == 3) ? 16'h10 : 16'h0);
            rd_chk(`NPE_OFF_STAT, 32'(esr[k]), "status", d);
            if (k == 0) rd_chk(`NPE_OFF_PAR, 32'h0, "clean syndrome", d);
            if (k == 1) begin
                rd_chk(`NPE_OFF_PAR, {16'h0, one}, "error location", d);
                rd_chk(`NPE_OFF_NPAR, {16'h0, ~one & {lm, cm}}, "inverse syndrome", d);
            end
            if (k == 3) begin
                axi_rd(`NPE_OFF_PAR, d, `NPE_RESP_OK);
                axi_rd(`NPE_OFF_NPAR, d2, `NPE_RESP_OK);
                chk("check bit position", d | d2, 32'h10);
            end
        end
    endtask : read_pass

    initial begin
        repeat (8) @(posedge ref_clk_in);
        rst_n_in <= 1'h1;
        reg_test();
        for (int c = 0; c < 4; c++) begin
            prog_pass(2'(c));
            read_pass(2'(c));
        end
        end_of_test();
    end

    // A hang is cut short well past the expected run of about fifty thousand cycles.
    initial begin
        #400_000;
        fail_count++;
        end_of_test();
    end
endmodule : testbench
